/* File: verilog/serial_card_control_registers.sv */
// Serial card: control registers, transmit FIFO, transmitter, receiver
`timescale 1ns/1ps
`default_nettype none

module tx_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input  wire logic             sys_clk,
    input  wire logic             reset,
    input  wire logic             clk_en,
    input  wire logic             flush,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_r;
    logic [AW-1:0]    rd_ptr_r;
    logic [AW:0]      count_r;
    logic             push;
    logic             pop;

    function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
        return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    assign in_ready  = count_r != (AW + 1)'(DEPTH);
    assign out_valid = count_r != '0;
    assign out_data  = mem[rd_ptr_r];
    assign push      = clk_en & in_valid & in_ready;
    assign pop       = clk_en & out_valid & out_ready;

    always_ff @(posedge sys_clk)
    begin
        if (push)
            mem[wr_ptr_r] <= in_data;
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset || flush)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end
        else
        begin
            if (push)
                wr_ptr_r <= ptr_inc(wr_ptr_r);
            if (pop)
                rd_ptr_r <= ptr_inc(rd_ptr_r);
            if (push && !pop)
                count_r <= count_r + 1'b1;
            else if (pop && !push)
                count_r <= count_r - 1'b1;
        end
    end
endmodule

module serial_card_control_registers
    import serial_card_pkg::*;
#(
    parameter int CLK_HZ     = SYS_CLK_HZ,
    parameter int FIFO_DEPTH = TX_FIFO_DEPTH
) (
    input  wire logic              sys_clk,
    input  wire logic              reset,
    input  wire logic              clk_en,
    input  wire reg_req_t          reg_req,
    output logic [15:0]            reg_rdata,
    input  wire logic [DATA_W-1:0] tx_data,
    input  wire logic              tx_valid,
    output logic                   tx_ready,
    output logic                   tx_idle,
    output logic [DATA_W-1:0]      rx_data,
    output logic                   rx_valid,
    input  wire logic              rx_ack,
    output logic                   rx_overrun,
    input  wire logic              overrun_clr,
    output logic                   ser_tx,
    input  wire logic              ser_rx
);
    logic [15:0]       line_rate_r;
    logic [15:0]       def_rate_r;
    fmt_t              char_fmt_r;
    fmt_t              def_fmt_r;
    logic              rate_ovr_r;
    logic              fmt_ovr_r;
    logic              xon_en_r;
    logic [15:0]       rdata_r;
    logic [15:0]       act_rate;
    fmt_t              act_fmt;
    logic              iface_rst;
    logic [DIV_W-1:0]  bit_div;
    logic [DIV_W-1:0]  div_m1;
    logic [2:0]        last;
    logic [DATA_W-1:0] f_data;
    logic              f_valid;
    logic              f_ready;
    tx_state_t         tx_state_r;
    logic [DIV_W-1:0]  tx_cnt_r;
    logic [2:0]        tx_idx_r;
    logic [7:0]        tx_shift_r;
    logic              tx_par_r;
    logic              ser_tx_r;
    logic              remote_stop_r;
    logic              tx_tick;
    logic              flow_req;
    logic              load_fifo;
    rx_state_t         rx_state_r;
    logic [DIV_W-1:0]  rx_cnt_r;
    logic [2:0]        rx_idx_r;
    logic [7:0]        rx_shift_r;
    logic [7:0]        rx_char;
    logic [7:0]        rx_data_r;
    logic              rx_valid_r;
    logic              overrun_r;
    logic              paused_r;
    logic              rx_tick;
    logic              rx_end;
    logic              rx_flow;
    logic              rx_deliver;

    function automatic logic wr_hit(input reg_req_t q, input logic [3:0] a);
        return q.wr && (q.addr == a);
    endfunction

    function automatic logic par_bit(input logic [7:0] d, input fmt_t f);
        logic [7:0] m;
        m = d & (8'hff >> (LAST_IDX_MAX - last_idx(f.len)));
        return (f.sense == SENSE_EVEN) ? ^m : ~^m;
    endfunction

    assign iface_rst = clk_en && wr_hit(reg_req, REG_IFACE_RST)
                       && (reg_req.wdata[7:0] != 8'h00);
    assign act_rate  = rate_ovr_r ? line_rate_r : def_rate_r;
    assign act_fmt   = fmt_ovr_r ? char_fmt_r : def_fmt_r;
    assign bit_div   = baud_div(CLK_HZ, act_rate);
    assign div_m1    = bit_div - 1'b1;
    assign last      = last_idx(act_fmt.len);

    // Register file
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            line_rate_r <= DEF_RATE_RST;
            def_rate_r  <= DEF_RATE_RST;
            char_fmt_r  <= DEF_FMT_RST;
            def_fmt_r   <= DEF_FMT_RST;
            rate_ovr_r  <= 1'b0;
            fmt_ovr_r   <= 1'b0;
            xon_en_r    <= 1'b0;
        end
        else if (clk_en)
        begin
            if (iface_rst)
                rate_ovr_r <= 1'b0;
            if (wr_hit(reg_req, REG_LINE_RATE))
            begin
                line_rate_r <= reg_req.wdata;
                rate_ovr_r  <= 1'b1;
            end
            if (wr_hit(reg_req, REG_CHAR_FMT))
            begin
                char_fmt_r <= reg_req.wdata[7:0];
                fmt_ovr_r  <= 1'b1;
                case (reg_req.wdata[7:6])
                    HS_XON:  xon_en_r <= 1'b1;
                    HS_OFF:  xon_en_r <= 1'b0;
                    default: xon_en_r <= xon_en_r;
                endcase
            end
            if (wr_hit(reg_req, REG_DEF_RATE))
                def_rate_r <= reg_req.wdata;
            if (wr_hit(reg_req, REG_DEF_FMT))
                def_fmt_r <= reg_req.wdata[7:0];
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
            rdata_r <= 16'h0000;
        else if (clk_en && reg_req.rd)
        begin
            case (reg_req.addr)
                REG_LINE_RATE: rdata_r <= act_rate;
                REG_CHAR_FMT:  rdata_r <= {8'h00, xon_en_r ? HS_XON : HS_OFF,
                                           act_fmt[5:0]};
                REG_DEF_RATE:  rdata_r <= def_rate_r;
                REG_DEF_FMT:   rdata_r <= {8'h00, def_fmt_r};
                default:       rdata_r <= 16'h0000;
            endcase
        end
    end
    assign reg_rdata = rdata_r;

    tx_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .sys_clk   (sys_clk),
        .reset     (reset),
        .clk_en    (clk_en),
        .flush     (iface_rst),
        .in_data   (tx_data),
        .in_valid  (tx_valid),
        .in_ready  (tx_ready),
        .out_data  (f_data),
        .out_valid (f_valid),
        .out_ready (f_ready)
    );

    // Transmitter; flow characters go ahead of queued data
    assign tx_tick   = tx_cnt_r == '0;
    assign flow_req  = xon_en_r && (rx_valid_r != remote_stop_r);
    assign load_fifo = (tx_state_r == TX_IDLE) && !flow_req && f_valid
                       && !(xon_en_r && paused_r);
    assign f_ready   = load_fifo;
    assign tx_idle   = (tx_state_r == TX_IDLE) && !f_valid;
    assign ser_tx    = ser_tx_r;

    always_ff @(posedge sys_clk)
    begin
        if (reset || iface_rst)
        begin
            tx_state_r    <= TX_IDLE;
            tx_cnt_r      <= '0;
            tx_idx_r      <= 3'h0;
            tx_shift_r    <= 8'h00;
            tx_par_r      <= 1'b0;
            ser_tx_r      <= 1'b1;
            remote_stop_r <= 1'b0;
        end
        else if (clk_en)
        begin
            if (tx_state_r != TX_IDLE)
                tx_cnt_r <= tx_tick ? div_m1 : tx_cnt_r - 1'b1;
            case (tx_state_r)
                TX_IDLE:
                    if (flow_req || load_fifo)
                    begin
                        tx_shift_r <= flow_req ?
                            (rx_valid_r ? CHAR_XOFF : CHAR_XON) : f_data;
                        tx_par_r   <= par_bit(flow_req ?
                            (rx_valid_r ? CHAR_XOFF : CHAR_XON) : f_data,
                            act_fmt);
                        if (flow_req)
                            remote_stop_r <= rx_valid_r;
                        ser_tx_r   <= 1'b0;
                        tx_cnt_r   <= div_m1;
                        tx_state_r <= TX_START;
                    end
                TX_START:
                    if (tx_tick)
                    begin
                        ser_tx_r   <= tx_shift_r[0];
                        tx_shift_r <= tx_shift_r >> 1;
                        tx_idx_r   <= 3'h0;
                        tx_state_r <= TX_DATA;
                    end
                TX_DATA:
                    if (tx_tick)
                    begin
                        if (tx_idx_r == last)
                        begin
                            tx_idx_r   <= 3'h0;
                            ser_tx_r   <= act_fmt.par_en ? tx_par_r : 1'b1;
                            tx_state_r <= act_fmt.par_en ? TX_PAR
                                                         : TX_STOP;
                        end
                        else
                        begin
                            ser_tx_r   <= tx_shift_r[0];
                            tx_shift_r <= tx_shift_r >> 1;
                            tx_idx_r   <= tx_idx_r + 1'b1;
                        end
                    end
                TX_PAR:
                    if (tx_tick)
                    begin
                        ser_tx_r   <= 1'b1;
                        tx_state_r <= TX_STOP;
                    end
                TX_STOP:
                    if (tx_tick)
                    begin
                        if (tx_idx_r < {2'b00, act_fmt.two_stop})
                            tx_idx_r <= tx_idx_r + 1'b1;
                        else
                            tx_state_r <= TX_IDLE;
                    end
                default:
                    tx_state_r <= TX_IDLE;
            endcase
        end
    end

    // Receiver with a single character buffer
    assign rx_tick    = rx_cnt_r == '0;
    assign rx_end     = clk_en && (rx_state_r == RX_STOP) && rx_tick;
    assign rx_char    = rx_shift_r >> (LAST_IDX_MAX - last);
    assign rx_flow    = xon_en_r && (rx_char == CHAR_XON
                                     || rx_char == CHAR_XOFF);
    assign rx_deliver = rx_end && !rx_flow;
    assign rx_data    = rx_data_r;
    assign rx_valid   = rx_valid_r;
    assign rx_overrun = overrun_r;

    always_ff @(posedge sys_clk)
    begin
        if (reset || iface_rst)
        begin
            rx_state_r <= RX_IDLE;
            rx_cnt_r   <= '0;
            rx_idx_r   <= 3'h0;
            rx_shift_r <= 8'h00;
        end
        else if (clk_en)
        begin
            if (rx_state_r != RX_IDLE)
                rx_cnt_r <= rx_tick ? div_m1 : rx_cnt_r - 1'b1;
            case (rx_state_r)
                RX_IDLE:
                    if (!ser_rx)
                    begin
                        rx_cnt_r   <= bit_div >> 1;
                        rx_state_r <= RX_START;
                    end
                RX_START:
                    if (rx_tick)
                    begin
                        rx_idx_r   <= 3'h0;
                        rx_state_r <= ser_rx ? RX_IDLE : RX_DATA;
                    end
                RX_DATA:
                    if (rx_tick)
                    begin
                        rx_shift_r <= {ser_rx, rx_shift_r[7:1]};
                        rx_idx_r   <= rx_idx_r + 1'b1;
                        if (rx_idx_r == last)
                            rx_state_r <= act_fmt.par_en ? RX_PAR : RX_STOP;
                    end
                RX_PAR:
                    if (rx_tick)
                        rx_state_r <= RX_STOP;
                RX_STOP:
                    if (rx_tick)
                        rx_state_r <= RX_IDLE;
                default:
                    rx_state_r <= RX_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset || iface_rst)
        begin
            rx_data_r  <= 8'h00;
            rx_valid_r <= 1'b0;
            overrun_r  <= 1'b0;
            paused_r   <= 1'b0;
        end
        else if (clk_en)
        begin
            if (rx_ack)
                rx_valid_r <= 1'b0;
            if (overrun_clr)
                overrun_r <= 1'b0;
            if (rx_end && rx_flow)
                paused_r <= rx_char == CHAR_XOFF;
            if (rx_deliver)
            begin
                rx_data_r  <= rx_char;
                rx_valid_r <= 1'b1;
                if (rx_valid_r && !rx_ack)
                    overrun_r <= 1'b1;
            end
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    sequence s_iface_rst;
        iface_rst;
    endsequence
    sequence s_fmt_wr;
        clk_en && wr_hit(reg_req, REG_CHAR_FMT);
    endsequence

    a_iface_rate: assert property (s_iface_rst
        |=> act_rate == def_rate_r && tx_state_r == TX_IDLE && !rx_valid_r)
        else $error("interface reset did not restore power-up state");
    a_iface_fmt: assert property (s_iface_rst
        |=> act_fmt == $past(act_fmt))
        else $error("interface reset altered the character format");
    a_rate_read: assert property (clk_en && reg_req.rd
        && reg_req.addr == REG_LINE_RATE |=> reg_rdata == $past(act_rate))
        else $error("line rate readback wrong");
    a_fmt_override: assert property (s_fmt_wr
        |=> act_fmt[5:0] == $past(reg_req.wdata[5:0]))
        else $error("written format did not take over");
    a_xon_on: assert property (s_fmt_wr
        ##0 reg_req.wdata[7:6] == HS_XON |=> xon_en_r)
        else $error("flow control not enabled");
    a_xon_off: assert property (s_fmt_wr
        ##0 reg_req.wdata[7:6] == HS_OFF |=> !xon_en_r)
        else $error("flow control not disabled");
    a_parity_gate: assert property (tx_state_r == TX_PAR
        |-> act_fmt.par_en)
        else $error("parity bit sent while parity disabled");
    a_stop_len: assert property (tx_state_r == TX_STOP
        |-> tx_idx_r <= {2'b00, act_fmt.two_stop})
        else $error("too many stop bits");
    a_data_len: assert property (tx_state_r == TX_DATA
        |-> tx_idx_r <= last)
        else $error("too many data bits");
    a_default_fmt: assert property (clk_en && !fmt_ovr_r
        && wr_hit(reg_req, REG_DEF_FMT)
        |=> act_fmt[5:0] == $past(reg_req.wdata[5:0]))
        else $error("default format not applied");
    a_default_rate: assert property (clk_en && !rate_ovr_r
        && wr_hit(reg_req, REG_DEF_RATE)
        |=> act_rate == $past(reg_req.wdata))
        else $error("default rate not applied");
    a_tx_done: assert property (tx_idle |-> ser_tx_r)
        else $error("transmit idle while line not at rest");
    a_overrun_set: assert property (rx_deliver && rx_valid_r && !rx_ack
        && !iface_rst |=> rx_overrun && rx_valid)
        else $error("overrun not flagged");
endmodule

`default_nettype wire

/* File: verilog/serial_card_pkg.sv */
// Constants and types for the serial card control registers
// Notes on behaviour
// - Writing a non-zero low byte to register zero restores the power-up state.
// - That interface reset leaves the active character format as it stands.
// - Line rate register takes one of sixteen rates, 50 to 19200, incl. 134.
// - Reading register three returns the active line rate in bits per second.
// - A written character format overrides the default format register.
// - Format bits 7:6: 00 no change, 01 Xon/Xoff both ways, 11 off.
// - Format bits 5:4 pick parity sense: 00 odd, 01 even.
// - Format bit 3 enables parity; when clear no parity bit is sent.
// - Format bit 2 picks one stop bit when clear, two when set.
// - Format bits 1:0 give five, six, seven or eight data bits.
// - Register fourteen holds the default format in the same layout.
// - Register thirteen holds the default line rate.
// - Transmit is idle only after the last bit of the last character left.
// - One received character is buffered; host must take it in time.
package serial_card_pkg;

    localparam int SYS_CLK_HZ    = 125_000_000;
    localparam int TX_FIFO_DEPTH = 4;
    localparam int DATA_W        = 8;
    localparam int DIV_W         = 22;

    localparam logic [3:0] REG_IFACE_RST = 4'h0;
    localparam logic [3:0] REG_LINE_RATE = 4'h3;
    localparam logic [3:0] REG_CHAR_FMT  = 4'h4;
    localparam logic [3:0] REG_DEF_RATE  = 4'hd;
    localparam logic [3:0] REG_DEF_FMT   = 4'he;

    localparam logic [15:0] DEF_RATE_RST = 16'h012c;
    localparam logic [7:0]  DEF_FMT_RST  = 8'h0e;

    localparam logic [1:0] HS_XON     = 2'h1;
    localparam logic [1:0] HS_OFF     = 2'h3;
    localparam logic [1:0] SENSE_EVEN = 2'h1;
    localparam logic [2:0] LAST_IDX_BASE = 3'h4;
    localparam logic [2:0] LAST_IDX_MAX  = 3'h7;
    localparam logic [7:0] CHAR_XON   = 8'h11;
    localparam logic [7:0] CHAR_XOFF  = 8'h13;

    localparam int RATE_COUNT = 16;
    localparam logic [15:0] RATE_TAB [RATE_COUNT] = '{
        16'h0032, 16'h004b, 16'h006e, 16'h0086, 16'h0096, 16'h00c8,
        16'h012c, 16'h0258, 16'h04b0, 16'h0708, 16'h0960, 16'h0e10,
        16'h12c0, 16'h1c20, 16'h2580, 16'h4b00};
    localparam logic [15:0] RATE_134      = 16'h0086;
    localparam logic [15:0] RATE_FALLBACK = 16'h2580;
    localparam int BAUD134_MUL = 2;
    localparam int BAUD134_DEN = 269;

    typedef struct packed {
        logic [1:0] hs;
        logic [1:0] sense;
        logic       par_en;
        logic       two_stop;
        logic [1:0] len;
    } fmt_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [3:0]  addr;
        logic [15:0] wdata;
    } reg_req_t;

    typedef enum logic [4:0] {
        TX_IDLE  = 5'h01,
        TX_START = 5'h02,
        TX_DATA  = 5'h04,
        TX_PAR   = 5'h08,
        TX_STOP  = 5'h10
    } tx_state_t;

    typedef enum logic [4:0] {
        RX_IDLE  = 5'h01,
        RX_START = 5'h02,
        RX_DATA  = 5'h04,
        RX_PAR   = 5'h08,
        RX_STOP  = 5'h10
    } rx_state_t;

    // Bit period in clock cycles; 134 stands for 134.5 baud
    function automatic logic [DIV_W-1:0] baud_div(input int clk_hz,
                                                  input logic [15:0] rate);
        int d;
        d = clk_hz / int'(RATE_FALLBACK);
        for (int i = 0; i < RATE_COUNT; i++)
            if (rate == RATE_TAB[i])
                d = clk_hz / int'(RATE_TAB[i]);
        if (rate == RATE_134)
            d = (clk_hz * BAUD134_MUL) / BAUD134_DEN;
        if (d < 1)
            d = 1;
        return d[DIV_W-1:0];
    endfunction

    function automatic logic [2:0] last_idx(input logic [1:0] len);
        return {1'b0, len} + LAST_IDX_BASE;
    endfunction

endpackage

/* File: verification/serial_peer.sv */
// Far-side serial peripheral model: sends characters and captures them
`timescale 1ns/1ps
`default_nettype none
module serial_peer
    import serial_card_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic [31:0] bit_div,
    input  wire fmt_t        fmt,
    input  wire logic        line_in,
    output logic             line_out,
    output logic [7:0]       got_data,
    output logic             got_par,
    output int               n_got
);
    int nb;
    assign nb = 5 + int'(fmt.len);

    task automatic wait_bits(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    // Start, data LSB first, optional parity, stop bits
    task automatic send(input logic [7:0] d);
        logic [7:0] m;
        m = d & (8'hff >> (8 - nb));
        line_out = 1'b0;
        wait_bits(bit_div);
        for (int i = 0; i < nb; i++)
        begin
            line_out = m[i];
            wait_bits(bit_div);
        end
        if (fmt.par_en)
        begin
            line_out = ^m ^ (fmt.sense != SENSE_EVEN);
            wait_bits(bit_div);
        end
        line_out = 1'b1;
        wait_bits(bit_div * (1 + int'(fmt.two_stop)));
    endtask

    initial
    begin
        line_out = 1'b1;
        n_got = 0;
        got_par = 1'b0;
    end

    // Capture each frame at mid-bit; count it only with a valid stop
    always
    begin
        @(negedge line_in);
        wait_bits(bit_div / 2);
        got_data = 8'h00;
        for (int i = 0; i < nb; i++)
        begin
            wait_bits(bit_div);
            got_data[i] = line_in;
        end
        if (fmt.par_en)
        begin
            wait_bits(bit_div);
            got_par = line_in;
        end
        wait_bits(bit_div);
        if (line_in === 1'b1)
            n_got++;
    end
endmodule
`default_nettype wire

/* File: verification/serial_card_control_registers_tb.sv */
// Testbench for the serial card control registers
`timescale 1ns/1ps
`default_nettype none
module serial_card_control_registers_tb;
    import serial_card_pkg::*;
    localparam int SIM_HZ  = 1_000_000;
    localparam int BIT_DIV = SIM_HZ / 19200;

    logic        sys_clk = 1'b0;
    logic        reset = 1'b1;
    reg_req_t    req = '0;
    logic [7:0]  tx_data = 8'h00;
    logic        tx_valid = 1'b0;
    logic        rx_ack = 1'b0;
    logic        overrun_clr = 1'b0;
    fmt_t        cur_fmt = DEF_FMT_RST;
    logic [15:0] reg_rdata;
    logic        tx_ready, tx_idle, rx_valid, rx_overrun, ser_tx, ser_rx;
    logic [7:0]  rx_data, got_data;
    logic        got_par;
    int          n_got;
    int          n_errors = 0;
    int          n_compared = 0;

    always #4 sys_clk = ~sys_clk;

    serial_card_control_registers #(.CLK_HZ(SIM_HZ))
        u_serial_card_control_registers (
        .sys_clk(sys_clk), .reset(reset), .clk_en(1'b1), .reg_req(req),
        .reg_rdata(reg_rdata), .tx_data(tx_data), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .tx_idle(tx_idle), .rx_data(rx_data),
        .rx_valid(rx_valid), .rx_ack(rx_ack), .rx_overrun(rx_overrun),
        .overrun_clr(overrun_clr), .ser_tx(ser_tx), .ser_rx(ser_rx));

    serial_peer u_serial_peer (
        .sys_clk(sys_clk), .bit_div(BIT_DIV), .fmt(cur_fmt), .line_in(ser_tx),
        .line_out(ser_rx), .got_data(got_data), .got_par(got_par),
        .n_got(n_got));

    task automatic finish_test();
        if (n_errors == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input string name, input logic [15:0] exp,
                       input logic [15:0] got);
        n_compared++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge sys_clk);
        req = '0;
        @(negedge sys_clk);
    endtask

    task automatic rd_chk(input string name, input logic [3:0] a,
                          input logic [15:0] exp);
        req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(negedge sys_clk);
        req = '0;
        chk(name, exp, reg_rdata);
        @(negedge sys_clk);
    endtask

    task automatic wait_idle(input int lim, output int cnt);
        cnt = 0;
        while (tx_idle !== 1'b1 && cnt < lim)
        begin
            @(negedge sys_clk);
            cnt++;
        end
        if (cnt >= lim)
        begin
            n_errors++;
            finish_test();
        end
    endtask

    task automatic t_regs();
        logic [1:0] hs[3] = '{HS_XON, 2'b00, HS_OFF};
        logic [1:0] ex[3] = '{HS_XON, HS_XON, HS_OFF};
        chk("rdata", 16'h0000, reg_rdata);
        chk("tx_idle", 16'h0001, {15'h0, tx_idle});
        rd_chk("rate", REG_LINE_RATE, DEF_RATE_RST);
        rd_chk("def rate", REG_DEF_RATE, DEF_RATE_RST);
        rd_chk("def fmt", REG_DEF_FMT, {8'h00, DEF_FMT_RST});
        rd_chk("fmt", REG_CHAR_FMT, {8'h00, HS_OFF, DEF_FMT_RST[5:0]});
        rd_chk("reset reg", REG_IFACE_RST, 16'h0000);
        wr(4'h5, 16'hffff);
        rd_chk("unmapped", 4'h5, 16'h0000);
        wr(REG_DEF_FMT, 16'h0003);
        rd_chk("fmt def", REG_CHAR_FMT, {8'h00, HS_OFF, 6'h03});
        for (int i = 0; i < 3; i++)
        begin
            wr(REG_CHAR_FMT, {8'h00, hs[i], 6'h0b});
            rd_chk("handshake", REG_CHAR_FMT, {8'h00, ex[i], 6'h0b});
        end
        wr(REG_DEF_RATE, 16'h4b00);
        rd_chk("rate def", REG_LINE_RATE, 16'h4b00);
        for (int i = 0; i < RATE_COUNT; i++)
        begin
            wr(REG_LINE_RATE, RATE_TAB[i]);
            rd_chk("rate", REG_LINE_RATE, RATE_TAB[i]);
        end
        rd_chk("def rate", REG_DEF_RATE, 16'h4b00);
    endtask

    task automatic t_tx(input fmt_t f, input logic [7:0] d);
        int cnt, nb, ex_t;
        logic [7:0] m;
        cur_fmt = f;
        wr(REG_CHAR_FMT, {8'h00, f});
        nb = 5 + int'(f.len);
        m = d & (8'hff >> (8 - nb));
        ex_t = 2 + BIT_DIV * (2 + nb + int'(f.par_en) + int'(f.two_stop));
        tx_data = d;
        tx_valid = 1'b1;
        @(negedge sys_clk);
        tx_valid = 1'b0;
        wait_idle(20000, cnt);
        chk("tx time", 16'h0001,
            {15'h0, cnt >= ex_t - 3 && cnt <= ex_t + 2});
        chk("tx data", {8'h00, m}, {8'h00, got_data});
        if (f.par_en)
            chk("tx par", {15'h0, ^m ^ (f.sense != SENSE_EVEN)},
                {15'h0, got_par});
    endtask

    task automatic t_fifo();
        int k, cnt, n0;
        n0 = n_got;
        k = 0;
        tx_valid = 1'b1;
        while (tx_ready === 1'b1 && k < 8)
        begin
            tx_data = 8'h30 + k[7:0];
            @(negedge sys_clk);
            k++;
        end
        tx_valid = 1'b0;
        chk("fifo refuses", 16'h0001,
            {15'h0, k >= TX_FIFO_DEPTH && k <= TX_FIFO_DEPTH + 1});
        wait_idle(20000, cnt);
        chk("chars out", 16'(n0 + k), 16'(n_got));
        chk("last char", {8'h00, 8'h2f + k[7:0]}, {8'h00, got_data});
    endtask

    task automatic t_rx();
        u_serial_peer.send(8'h3c);
        chk("rx data", 16'h003c, {8'h00, rx_data});
        chk("rx flags", 16'h0002, {14'h0, rx_valid, rx_overrun});
        u_serial_peer.send(8'hc3);
        chk("rx newest", 16'h00c3, {8'h00, rx_data});
        chk("rx flags", 16'h0003, {14'h0, rx_valid, rx_overrun});
        rx_ack = 1'b1;
        overrun_clr = 1'b1;
        @(negedge sys_clk);
        rx_ack = 1'b0;
        overrun_clr = 1'b0;
        chk("rx cleared", 16'h0000, {14'h0, rx_valid, rx_overrun});
    endtask

    task automatic t_ifreset();
        u_serial_peer.send(8'h5a);
        wr(REG_CHAR_FMT, 16'h001f);
        wr(REG_LINE_RATE, 16'h0960);
        wr(REG_IFACE_RST, 16'h0000);
        chk("zero write", 16'h0001, {15'h0, rx_valid});
        wr(REG_IFACE_RST, 16'h0100);
        chk("upper bits", 16'h0001, {15'h0, rx_valid});
        wr(REG_IFACE_RST, 16'h0001);
        chk("iface reset", 16'h0000, {14'h0, rx_valid, rx_overrun});
        rd_chk("rate back", REG_LINE_RATE, 16'h4b00);
        rd_chk("fmt kept", REG_CHAR_FMT, {8'h00, HS_OFF, 6'h1f});
        t_tx(8'hdf, 8'h96);
    endtask

    task automatic t_flow();
        int cnt;
        cur_fmt = 8'h43;
        wr(REG_CHAR_FMT, 16'h0043);
        u_serial_peer.send(8'h77);
        wait_idle(2000, cnt);
        chk("xoff", {8'h00, CHAR_XOFF}, {8'h00, got_data});
        rx_ack = 1'b1;
        @(negedge sys_clk);
        rx_ack = 1'b0;
        @(negedge sys_clk);
        wait_idle(2000, cnt);
        chk("xon", {8'h00, CHAR_XON}, {8'h00, got_data});
        u_serial_peer.send(CHAR_XOFF);
        chk("flow eaten", 16'h0000, {15'h0, rx_valid});
    endtask

    initial
    begin
        repeat (5) @(negedge sys_clk);
        reset = 1'b0;
        t_regs();
        t_tx(8'h0b, 8'ha5);
        t_tx(8'h1f, 8'h5a);
        t_tx(8'h00, 8'h6d);
        t_tx(8'h05, 8'hb2);
        t_tx(8'h0a, 8'h4e);
        t_tx(8'h03, 8'h81);
        t_fifo();
        t_rx();
        t_ifreset();
        t_flow();
        finish_test();
    end
endmodule
`default_nettype wire
